// File: src/cspc_defs.svh
// constants for the cpu sideband power state controller
`ifndef CSPC_DEFS_SVH
`define CSPC_DEFS_SVH

`define CSPC_SYNC_RST      4'hf
`define CSPC_SYNC_BITS     4
`define CSPC_SB_MGMT       0
`define CSPC_SB_STOP       1
`define CSPC_SB_DEEP       2
`define CSPC_SB_DEEPER     3

`endif

// File: src/cspc_pkg.sv
// types for the cpu sideband power state controller
package cspc_pkg;

    typedef enum logic [3:0] {
        CSPC_RUN,
        CSPC_SMM_ACK,
        CSPC_SMM,
        CSPC_STOP_ACK,
        CSPC_STOP_GRANT,
        CSPC_SLEEP,
        CSPC_DEEP_SLEEP,
        CSPC_DEEPER_SLEEP,
        CSPC_PROBE
    } cspc_state_t;

    typedef enum logic [1:0] {
        CSPC_TXN_NONE,
        CSPC_TXN_SMI_ACK,
        CSPC_TXN_STOP_ACK
    } cspc_txn_t;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic        probe_s1;
        logic        probe_s2;
        logic        sleep_s1;
        logic        sleep_s2;
        cspc_state_t state;
        cspc_state_t resume;
        cspc_txn_t   txn;
        logic        txn_valid;
        logic        core_clk_en;
        logic        probe_ready_n;
        logic        pbe_n;
        logic        smm_active;
    } cspc_reg_t;

endpackage : cspc_pkg

// File: src/cspc_ctrl.sv
// cpu sideband power state controller: sync, state machine, outputs
`include "cspc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cspc_ctrl
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       mgmt_irq_n,
    input  wire logic       stop_clock_req_n,
    input  wire logic       probe_request_n,
    input  wire logic       sleep_req_n,
    input  wire logic       deep_sleep_req_n,
    input  wire logic       deeper_sleep_req_n,
    input  wire logic       probe_wake_en,
    input  wire logic       break_event,
    input  wire logic       handler_done,
    input  wire logic       probe_exit,
    input  wire logic       txn_ready,
    output logic            txn_valid,
    output cspc_pkg::cspc_txn_t txn_type,
    output logic            core_clk_en,
    output logic            snoop_irq_en,
    output logic            smm_active,
    output logic            probe_ready_n,
    output logic            pending_break_event_n,
    output cspc_pkg::cspc_state_t power_state
);

    // ==========================================================
    // state
    cspc_pkg::cspc_reg_t r_q;
    cspc_pkg::cspc_reg_t r_d;

    logic mgmt_s;
    logic stop_s;
    logic deep_s;
    logic deeper_s;
    logic probe_s;
    logic sleep_s;
    logic low_power;

    // ==========================================================
    // synchronised levels, active high
    assign mgmt_s   = ~r_q.sync2[`CSPC_SB_MGMT];
    assign stop_s   = ~r_q.sync2[`CSPC_SB_STOP];
    assign deep_s   = ~r_q.sync2[`CSPC_SB_DEEP];
    assign deeper_s = ~r_q.sync2[`CSPC_SB_DEEPER];
    assign probe_s  = ~r_q.probe_s2;
    assign sleep_s  = ~r_q.sleep_s2;
    // deep and deeper sleep stand for the c4 and c6 states
    assign low_power = (r_q.state == cspc_pkg::CSPC_DEEP_SLEEP) ||
                       (r_q.state == cspc_pkg::CSPC_DEEPER_SLEEP);

    // ==========================================================
    // next state
    always_comb
    begin
        r_d = r_q;
        // two flops per asynchronous input
        r_d.sync1    = {deeper_sleep_req_n, deep_sleep_req_n,
                        stop_clock_req_n, mgmt_irq_n};
        r_d.sync2    = r_q.sync1;
        r_d.probe_s1 = probe_request_n;
        r_d.probe_s2 = r_q.probe_s1;
        r_d.sleep_s1 = sleep_req_n;
        r_d.sleep_s2 = r_q.sleep_s1;

        if (r_q.txn_valid && txn_ready)
        begin
            r_d.txn_valid = 1'b0;
            r_d.txn       = cspc_pkg::CSPC_TXN_NONE;
        end

        unique case (r_q.state)
            cspc_pkg::CSPC_RUN:
            begin
                if (probe_s)
                    r_d.state = cspc_pkg::CSPC_PROBE;
                else if (mgmt_s)
                begin
                    r_d.state      = cspc_pkg::CSPC_SMM_ACK;
                    r_d.smm_active = 1'b1;
                    r_d.txn_valid  = 1'b1;
                    r_d.txn        = cspc_pkg::CSPC_TXN_SMI_ACK;
                end
                else if (stop_s)
                begin
                    r_d.state     = cspc_pkg::CSPC_STOP_ACK;
                    r_d.txn_valid = 1'b1;
                    r_d.txn       = cspc_pkg::CSPC_TXN_STOP_ACK;
                end
            end
            cspc_pkg::CSPC_SMM_ACK:
            begin
                if (r_q.txn_valid && txn_ready)
                    r_d.state = cspc_pkg::CSPC_SMM;
            end
            cspc_pkg::CSPC_SMM:
            begin
                if (handler_done)
                begin
                    r_d.state      = cspc_pkg::CSPC_RUN;
                    r_d.smm_active = 1'b0;
                end
            end
            cspc_pkg::CSPC_STOP_ACK:
            begin
                if (r_q.txn_valid && txn_ready)
                begin
                    r_d.state       = cspc_pkg::CSPC_STOP_GRANT;
                    r_d.core_clk_en = 1'b0;
                end
            end
            cspc_pkg::CSPC_STOP_GRANT:
            begin
                if (!stop_s)
                begin
                    r_d.state       = cspc_pkg::CSPC_RUN;
                    r_d.core_clk_en = 1'b1;
                end
                else if (sleep_s)
                    r_d.state = cspc_pkg::CSPC_SLEEP;
            end
            cspc_pkg::CSPC_SLEEP:
            begin
                if (deep_s)
                    r_d.state = cspc_pkg::CSPC_DEEP_SLEEP;
                else if (!sleep_s)
                    r_d.state = cspc_pkg::CSPC_STOP_GRANT;
            end
            cspc_pkg::CSPC_DEEP_SLEEP:
            begin
                if (probe_s && probe_wake_en)
                begin
                    r_d.resume = r_q.state;
                    r_d.state  = cspc_pkg::CSPC_PROBE;
                end
                else if (!deep_s)
                    r_d.state = cspc_pkg::CSPC_SLEEP;
                else if (deeper_s)
                    r_d.state = cspc_pkg::CSPC_DEEPER_SLEEP;
            end
            cspc_pkg::CSPC_DEEPER_SLEEP:
            begin
                if (probe_s && probe_wake_en)
                begin
                    r_d.resume = r_q.state;
                    r_d.state  = cspc_pkg::CSPC_PROBE;
                end
                else if (!deeper_s)
                    r_d.state = cspc_pkg::CSPC_DEEP_SLEEP;
            end
            cspc_pkg::CSPC_PROBE:
            begin
                if (probe_exit && !probe_s)
                    r_d.state = r_q.resume;
            end
        endcase

        // probe wake restarts core clocks; resume state restores gating
        if (r_d.state == cspc_pkg::CSPC_PROBE)
            r_d.core_clk_en = 1'b1;
        else if (r_q.state == cspc_pkg::CSPC_PROBE &&
                 r_d.state != cspc_pkg::CSPC_RUN)
            r_d.core_clk_en = 1'b0;
        if (r_d.state != cspc_pkg::CSPC_PROBE)
            r_d.resume = (r_d.state == cspc_pkg::CSPC_PROBE) ? r_d.resume :
                         (r_q.state == cspc_pkg::CSPC_PROBE) ?
                         cspc_pkg::CSPC_RUN : r_d.resume;

        r_d.probe_ready_n = ~(r_q.state == cspc_pkg::CSPC_PROBE);
        // break request only while stop clock is held
        r_d.pbe_n = ~(stop_s && break_event &&
                      (low_power ||
                       r_q.state == cspc_pkg::CSPC_STOP_GRANT ||
                       r_q.state == cspc_pkg::CSPC_SLEEP));

        if (sys_rst)
        begin
            r_d               = '0;
            r_d.sync1         = `CSPC_SYNC_RST;
            r_d.sync2         = `CSPC_SYNC_RST;
            r_d.probe_s1      = 1'b1;
            r_d.probe_s2      = 1'b1;
            r_d.sleep_s1      = 1'b1;
            r_d.sleep_s2      = 1'b1;
            r_d.state         = cspc_pkg::CSPC_RUN;
            r_d.resume        = cspc_pkg::CSPC_RUN;
            r_d.txn           = cspc_pkg::CSPC_TXN_NONE;
            r_d.core_clk_en   = 1'b1;
            r_d.probe_ready_n = 1'b1;
            r_d.pbe_n         = 1'b1;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk)
    begin
        r_q <= r_d;
    end

    // ==========================================================
    // outputs
    assign txn_valid             = r_q.txn_valid;
    assign txn_type              = r_q.txn;
    assign core_clk_en           = r_q.core_clk_en;
    assign snoop_irq_en          = 1'b1;
    assign smm_active            = r_q.smm_active;
    assign probe_ready_n         = r_q.probe_ready_n;
    assign pending_break_event_n = r_q.pbe_n;
    assign power_state           = r_q.state;

endmodule : cspc_ctrl

`default_nettype wire

// File: sim/cspc_bus_model.sv
// bus-side model that accepts the acknowledge transactions
`timescale 1ns/1ps
`default_nettype none
module cspc_bus_model
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic txn_valid,
    input  wire logic stall,
    output var logic  txn_ready
);
    // one-cycle accept; a stall holds the device's request waiting
    always_ff @(posedge clk)
        txn_ready <= !sys_rst && txn_valid && !txn_ready && !stall;
endmodule : cspc_bus_model
`default_nettype wire

// File: sim/cspc_ctrl_monitor.sv
// port checks for the sideband power state controller
`timescale 1ns/1ps
`default_nettype none
module cspc_ctrl_monitor
(
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  stop_clock_req_n,
    input wire logic                  txn_ready,
    input wire logic                  txn_valid,
    input wire cspc_pkg::cspc_txn_t   txn_type,
    input wire logic                  core_clk_en,
    input wire logic                  snoop_irq_en,
    input wire logic                  smm_active,
    input wire logic                  probe_ready_n,
    input wire logic                  pending_break_event_n,
    input wire cspc_pkg::cspc_state_t power_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ====================================
    // assertions
    AST_PBE_IDLE: assert property (
        stop_clock_req_n [*5] |-> pending_break_event_n) else $error("pbe");
    AST_STOP_ACK: assert property (
        $changed(power_state) && power_state == cspc_pkg::CSPC_STOP_ACK
        |-> txn_valid && txn_type == cspc_pkg::CSPC_TXN_STOP_ACK)
        else $error("stop ack");
    AST_SMI_ACK: assert property (
        $rose(smm_active) |-> power_state == cspc_pkg::CSPC_SMM_ACK
        && txn_valid && txn_type == cspc_pkg::CSPC_TXN_SMI_ACK)
        else $error("smi ack");
    AST_TXN_HOLD: assert property (
        txn_valid && !txn_ready |=> txn_valid && $stable(txn_type))
        else $error("txn drop");
    AST_GATE: assert property (
        power_state == cspc_pkg::CSPC_STOP_GRANT |-> !core_clk_en)
        else $error("gate");
    AST_SNOOP_LIVE: assert property (
        power_state == cspc_pkg::CSPC_STOP_GRANT |-> snoop_irq_en)
        else $error("snoop");
    AST_RESUME: assert property (
        power_state == cspc_pkg::CSPC_RUN |-> core_clk_en) else $error("clk");
    AST_PROBE_RDY: assert property (
        power_state == cspc_pkg::CSPC_PROBE [*2] |-> !probe_ready_n)
        else $error("probe ready");
    AST_DEEPER_FROM: assert property (
        $changed(power_state) && power_state == cspc_pkg::CSPC_DEEPER_SLEEP
        |-> $past(power_state) inside {cspc_pkg::CSPC_DEEP_SLEEP,
        cspc_pkg::CSPC_PROBE}) else $error("deeper entry");
    AST_SYNC: assert property (
        $fell(stop_clock_req_n) && power_state == cspc_pkg::CSPC_RUN
        |=> (power_state != cspc_pkg::CSPC_STOP_ACK) [*2]) else $error("sync");
    C_GRANT: cover property (power_state == cspc_pkg::CSPC_STOP_GRANT);
    C_DEEPER: cover property (power_state == cspc_pkg::CSPC_DEEPER_SLEEP);
    C_PROBE: cover property (power_state == cspc_pkg::CSPC_PROBE);
endmodule : cspc_ctrl_monitor
bind cspc_ctrl cspc_ctrl_monitor mon (.*);
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the sideband power state controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk = 1'b0, sys_rst = 1'b1, stall = 1'b0;
    logic       wake_en = 1'b0, brk = 1'b0, hdone = 1'b0, pexit = 1'b0;
    logic [5:0] sb = 6'h3f;
    logic       ready, valid, pbe_n, probe_ready_n_n, system_management_mode;
    logic [3:0] last_st = 4'h0;
    logic [3:0] q[$];
    int         num_errors = 0, n_compared = 0;
    cspc_pkg::cspc_state_t st;

    always #4 clk = ~clk;
    always @(posedge clk) stall <= 1'($urandom);

    cspc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .mgmt_irq_n(sb[5]),
        .stop_clock_req_n(sb[4]), .probe_request_n(sb[3]),
        .sleep_req_n(sb[2]), .deep_sleep_req_n(sb[1]),
        .deeper_sleep_req_n(sb[0]), .probe_wake_en(wake_en),
        .break_event(brk), .handler_done(hdone), .probe_exit(pexit),
        .txn_ready(ready), .txn_valid(valid), .txn_type(), .core_clk_en(),
        .snoop_irq_en(), .smm_active(system_management_mode), .probe_ready_n(probe_ready_n_n),
        .pending_break_event_n(pbe_n), .power_state(st));
    cspc_bus_model bus (.clk(clk), .sys_rst(sys_rst), .txn_valid(valid),
        .stall(stall), .txn_ready(ready));

    // ====================================
    // checking and closing
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // drive the sideband levels, note the expected state, wait it out
    task automatic go(input logic [5:0] v, input logic [3:0] e);
        sb <= v;
        if (e != 4'hf)
            q.push_back(e);
        for (int i = 0; i < 80 && q.size() != 0; i++)
            @(posedge clk);
        if (q.size() != 0)
        begin
            num_errors++;
            finish_test();
        end
        repeat (6) @(posedge clk);
    endtask : go

    // any state change takes the oldest note; none noted is a mismatch
    always @(negedge clk)
    begin
        if (!sys_rst && st !== last_st)
            chk(st, q.size() != 0 ? q.pop_front() : last_st);
        last_st <= st;
    end

    // ====================================
    // scenarios
    initial
    begin
        void'($urandom(32'hc780));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        brk <= 1'b1;
        q.push_back(cspc_pkg::CSPC_STOP_ACK);
        go(6'h2f, cspc_pkg::CSPC_STOP_GRANT);
        chk({3'h0, pbe_n}, 4'h0);
        go(6'h2b, cspc_pkg::CSPC_SLEEP);
        go(6'h2a, 4'hf);
        go(6'h29, cspc_pkg::CSPC_DEEP_SLEEP);
        go(6'h28, cspc_pkg::CSPC_DEEPER_SLEEP);
        chk({3'h0, pbe_n}, 4'h0);
        go(6'h20, 4'hf);
        wake_en <= 1'b1;
        go(6'h20, cspc_pkg::CSPC_PROBE);
        pexit <= 1'b1;
        go(6'h28, cspc_pkg::CSPC_DEEPER_SLEEP);
        pexit <= 1'b0;
        go(6'h29, cspc_pkg::CSPC_DEEP_SLEEP);
        go(6'h2b, cspc_pkg::CSPC_SLEEP);
        go(6'h2f, cspc_pkg::CSPC_STOP_GRANT);
        go(6'h3f, cspc_pkg::CSPC_RUN);
        $display("test stop and sleep done");
        q.push_back(cspc_pkg::CSPC_SMM_ACK);
        go(6'h1f, cspc_pkg::CSPC_SMM);
        chk({3'h0, system_management_mode}, 4'h1);
        go(6'h3f, 4'hf);
        hdone <= 1'b1;
        go(6'h3f, cspc_pkg::CSPC_RUN);
        chk({3'h0, system_management_mode}, 4'h0);
        hdone <= 1'b0;
        $display("test management done");
        go(6'h37, cspc_pkg::CSPC_PROBE);
        chk({3'h0, probe_ready_n_n}, 4'h0);
        pexit <= 1'b1;
        go(6'h3f, cspc_pkg::CSPC_RUN);
        $display("test probe done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
